// [src/spu_pkg.sv]
// Package of constants, types and register map for the serial port block
// Summary of operation
// R1 - Machine cycle spans six CPU clocks; serial timing keys off machine cycle states.
// R2 - Mode 0 shifts eight bits LSB first at one sixth of CPU clock.
// R3 - Mode 0 receive starts on enable with done flag clear; preload 1111110 (code loads 11111110 under a ninth bit one).
// R4 - Mode 0 receive drives shift clock, toggling at S3P1 and S6P1.
// R5 - Mode 0 shifts left at S6P2, bringing in the value sampled at S5P2.
// R6 - Zero at left end triggers last shift, buffer load, flag set next S1P1.
// R7 - Mode 1 frame: start zero, eight data LSB first, stop one into ninth flag.
// R8 - Modes 1 and 3 use timer overflow rate, divided by sixteen per bit.
// R9 - Buffer write loads marker one; send starts after next divide-by-16 rollover.
// R10 - Start bit first, data output one bit later, first shift one bit after.
// R11 - Zeros fill from left; marker position triggers last shift and done flag.
// R12 - Receiver samples at 16x; falling edge resets counter and loads 1FFH.
// R13 - Each bit sampled at counter states 7, 8, 9; majority wins.
// R14 - Nonzero start bit resets receiver to hunt for a new falling edge.
// R15 - Mode 1 load and flag only if flag clear and filter off or stop one.
// R16 - Modes 2 and 3 resume hunting one bit time after frame end.
// R17 - Modes 2 and 3 frame: start, eight data, ninth bit, stop; ninth stored.
// R18 - Mode 2 rate is CPU clock over 16 or 32; mode 3 uses timer.
// R19 - Modes 2 and 3 load ninth bit; first shift inserts stop; 11 rollovers.
// R20 - Modes 2 and 3 load only if flag clear and filter off or ninth one.
// R21 - Filtering ignored in mode 0; mode 1 filtering needs valid stop bit.
// R22 - Master marks addresses with ninth bit one, data with ninth bit zero.
// R23 - Done flags stay set until software clears them; any set flag interrupts.
package spu_pkg;
    // Register indexes on the plain register port
    localparam logic [1:0] SPU_REG_CTRL = 2'h0;
    localparam logic [1:0] SPU_REG_BUF = 2'h1;
    localparam logic [1:0] SPU_REG_CFG = 2'h2;
    // Control and config register fields
    localparam int SPU_CTL_RXDONE = 0;
    localparam int SPU_CTL_TXDONE = 1;
    localparam int SPU_CTL_RX9 = 2;
    localparam int SPU_CTL_TX9 = 3;
    localparam int SPU_CTL_REN = 4;
    localparam int SPU_CTL_MPF = 5;
    localparam int SPU_CTL_MODE_LO = 6;
    localparam int SPU_CFG_DIV32 = 0;
    localparam logic [7:0] SPU_CTRL_RESET = 8'h00;
    // Timing constants and receive shift preloads
    localparam int SPU_CPU_PER_MC = 6;
    localparam int SPU_CPU_PER_PHASE = SPU_CPU_PER_MC / 6;
    localparam logic [3:0] SPU_SAMP_A = 4'h7;
    localparam logic [3:0] SPU_SAMP_B = 4'h8;
    localparam logic [3:0] SPU_SAMP_C = 4'h9;
    localparam logic [3:0] SPU_BIT_LAST = 4'hf;
    localparam logic [8:0] SPU_RX_PRELOAD = 9'h1ff;
    localparam logic [7:0] SPU_M0_PRELOAD = 8'hfe;
    // Machine cycle states S1..S6 as index 0..5
    localparam logic [2:0] SPU_S1 = 3'h0;
    localparam logic [2:0] SPU_S3 = 3'h2;
    localparam logic [2:0] SPU_S5 = 3'h4;
    localparam logic [2:0] SPU_S6 = 3'h5;
    typedef enum logic [1:0] {
        SPU_RX_IDLE = 2'b00,
        SPU_RX_BITS = 2'b01,
        SPU_RX_HOLD = 2'b10,
        SPU_RX_M0 = 2'b11
    } spu_rx_state_t;
    typedef enum logic [1:0] {
        SPU_TX_IDLE = 2'b00,
        SPU_TX_WAIT = 2'b01,
        SPU_TX_SEND = 2'b10
    } spu_tx_state_t;
endpackage

// [src/spu_uart.sv]
// Serial port: mode 0 receive, mode 1 and modes 2/3 asynchronous frames
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ps
module spu_uart (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic timer_overflow,
    input wire logic shift_data_pin_in,
    output logic shift_data_pin_out,
    output logic shift_data_pin_oe,
    output logic shift_clock_pin,
    output logic serial_irq
);
    import spu_pkg::*;

    typedef struct packed {
        logic [7:0] rdata;
        logic [7:0] ctrl;
        logic div32;
        logic [7:0] serial_buffer;
        logic [2:0] phase_state;
        logic phase;
        logic [4:0] m2_div;
        logic tick16;
        logic [3:0] tx_cnt;
        logic tx_roll;
        spu_tx_state_t tx_st;
        logic [8:0] tx_sh;
        logic [3:0] tx_bits;
        logic tx_data_en;
        logic txd;
        logic [3:0] rx_cnt;
        spu_rx_state_t rx_st;
        logic [8:0] rx_sh;
        logic [2:0] votes;
        logic rxd_prev;
        logic m0_s5;
        logic m0_arm;
        logic m0_last;
        logic sclk;
        logic [3:0] m0_cyc;
        logic irq;
    } spu_state_t;

    spu_state_t st;
    spu_state_t next_st;

    logic [1:0] mode;
    logic ctl_wr;
    logic buf_wr;
    logic s1p1;
    logic rollover;
    logic rx_bit;
    logic rx_ok;
    logic rx_frame_ninth;
    logic fin9;

    // Decode of software accesses and machine cycle timing points
    assign mode = st.ctrl[SPU_CTL_MODE_LO+1:SPU_CTL_MODE_LO];
    assign ctl_wr = reg_wr && reg_addr == SPU_REG_CTRL;
    assign buf_wr = reg_wr && reg_addr == SPU_REG_BUF;
    assign s1p1 = st.phase_state == SPU_S1 && !st.phase; // [R1]
    assign rollover = st.tick16 && st.tx_cnt == SPU_BIT_LAST;
    assign rx_bit = (st.votes[0] & st.votes[1]) | (st.votes[1] & st.votes[2])
        | (st.votes[0] & st.votes[2]); // [R13]

    always_comb begin
        next_st = st;
        rx_ok = 1'b0;
        rx_frame_ninth = 1'b0;
        fin9 = 1'b0;
        // One phase per ref_clk edge; each state has two phases
        next_st.phase = ~st.phase; // [R1]
        if (st.phase) begin
            next_st.phase_state = st.phase_state == SPU_S6 ? SPU_S1 : st.phase_state + 3'h1;
        end
        // Mode 2 runs the 16x tick from the CPU clock, others from the timer
        next_st.m2_div = st.m2_div + 5'h1;
        if (mode == 2'b10) begin
            // One ref_clk is one phase, so the CPU clock runs at half its rate
            next_st.tick16 = st.div32 ? st.m2_div[1:0] == 2'h3 : st.m2_div[0]; // [R18]
        end else begin
            next_st.tick16 = timer_overflow; // [R8]
        end
        // Free running divide-by-16 for transmit bit times
        if (st.tick16) begin
            next_st.tx_cnt = st.tx_cnt + 4'h1; // [R8]
        end
        if (rollover) begin
            next_st.tx_roll = 1'b1;
        end
        if (s1p1) begin
            next_st.tx_roll = 1'b0;
        end

        // Register writes; done flag sets below keep priority over these clears
        if (ctl_wr) begin
            next_st.ctrl = reg_wdata;
        end
        if (reg_wr && reg_addr == SPU_REG_CFG) begin
            next_st.div32 = reg_wdata[SPU_CFG_DIV32];
        end
        next_st.rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                SPU_REG_CTRL: next_st.rdata = st.ctrl;
                SPU_REG_BUF: next_st.rdata = st.serial_buffer;
                SPU_REG_CFG: next_st.rdata = {7'h00, st.div32};
                default: next_st.rdata = 8'h00;
            endcase
        end

        // Transmitter for modes 1..3
        unique case (st.tx_st)
            SPU_TX_IDLE: begin
                if (buf_wr && mode != 2'b00) begin
                    next_st.tx_sh = {mode == 2'b01 ? 1'b1 : st.ctrl[SPU_CTL_TX9],
                        reg_wdata}; // [R9] [R19]
                    next_st.tx_bits = 4'h0;
                    next_st.tx_roll = 1'b0;
                    next_st.tx_st = SPU_TX_WAIT;
                end
            end
            SPU_TX_WAIT: begin
                // Bit times align to the counter, not to the write
                if (st.tx_roll && s1p1) begin
                    next_st.txd = 1'b0; // [R9] [R10]
                    next_st.tx_data_en = 1'b0;
                    next_st.tx_st = SPU_TX_SEND;
                end
            end
            SPU_TX_SEND: begin
                if (rollover) begin
                    next_st.tx_bits = st.tx_bits + 4'h1;
                    if (!st.tx_data_en) begin
                        next_st.tx_data_en = 1'b1; // [R10]
                        next_st.txd = st.tx_sh[0];
                    end else begin
                        // First shift of 11-bit frames inserts the stop bit
                        fin9 = mode != 2'b01 && st.tx_bits == 4'h1;
                        next_st.tx_sh = {fin9, st.tx_sh[8:1]}; // [R11] [R19]
                        next_st.txd = st.tx_sh[1];
                        // The stop-inserting shift may look like the end pattern; skip it
                        if (st.tx_sh[8:1] == 8'h01 && !fin9) begin
                            // Last shift: stop level out, done flag raised
                            next_st.txd = 1'b1;
                            next_st.tx_data_en = 1'b0;
                            next_st.ctrl[SPU_CTL_TXDONE] = 1'b1; // [R11] [R19] [R23]
                            next_st.tx_st = SPU_TX_IDLE;
                        end
                    end
                end
            end
            default: next_st.tx_st = SPU_TX_IDLE;
        endcase

        // Receiver
        next_st.rxd_prev = shift_data_pin_in; // [R12]
        if (st.tick16) begin
            next_st.rx_cnt = st.rx_cnt + 4'h1;
            if (st.rx_cnt == SPU_SAMP_A || st.rx_cnt == SPU_SAMP_B
                    || st.rx_cnt == SPU_SAMP_C) begin
                next_st.votes = {st.votes[1:0], shift_data_pin_in}; // [R13]
            end
        end
        unique case (st.rx_st)
            SPU_RX_IDLE: begin
                if (mode == 2'b00) begin
                    // Mode 0 arms on enable with done flag clear
                    if (st.ctrl[SPU_CTL_REN] && !st.ctrl[SPU_CTL_RXDONE]
                            && st.phase_state == SPU_S6 && st.phase) begin
                        next_st.rx_sh = {1'b1, SPU_M0_PRELOAD}; // [R3]
                        next_st.m0_cyc = 4'h0;
                        next_st.m0_last = 1'b0;
                        next_st.rx_st = SPU_RX_M0;
                    end
                end else if (st.ctrl[SPU_CTL_REN] && st.rxd_prev && !shift_data_pin_in) begin
                    next_st.rx_cnt = 4'h0; // [R12]
                    next_st.rx_sh = SPU_RX_PRELOAD; // [R12]
                    next_st.rx_st = SPU_RX_BITS;
                end
            end
            SPU_RX_BITS: begin
                if (st.tick16 && st.rx_cnt == SPU_BIT_LAST) begin
                    if (st.rx_sh == SPU_RX_PRELOAD && rx_bit) begin
                        next_st.rx_st = SPU_RX_IDLE; // [R14]
                    end else if (!st.rx_sh[8]) begin
                        // Start bit reached the left end: the bit now voted is stop or ninth
                        rx_frame_ninth = rx_bit;
                        rx_ok = !st.ctrl[SPU_CTL_RXDONE]
                            && (!st.ctrl[SPU_CTL_MPF] || rx_frame_ninth); // [R15] [R20] [R21]
                        if (rx_ok) begin
                            // First bit in sits highest; reverse so bit 0 is the LSB
                            next_st.serial_buffer = {st.rx_sh[0], st.rx_sh[1], st.rx_sh[2],
                                st.rx_sh[3], st.rx_sh[4], st.rx_sh[5], st.rx_sh[6], st.rx_sh[7]};
                            next_st.ctrl[SPU_CTL_RX9] = rx_frame_ninth; // [R7] [R17]
                            next_st.ctrl[SPU_CTL_RXDONE] = 1'b1; // [R23]
                        end
                        next_st.rx_st = mode == 2'b01 ? SPU_RX_IDLE : SPU_RX_HOLD;
                    end else begin
                        next_st.rx_sh = {st.rx_sh[7:0], rx_bit};
                    end
                end
            end
            SPU_RX_HOLD: begin
                // Idle one bit time before hunting again
                if (st.tick16 && st.rx_cnt == SPU_BIT_LAST) begin
                    next_st.rx_st = SPU_RX_IDLE; // [R16]
                end
            end
            SPU_RX_M0: begin
                // Shift clock low through S3..S5, high through S6..S2
                if (!st.phase && st.phase_state == SPU_S3) begin
                    next_st.sclk = 1'b0; // [R4]
                end
                if (!st.phase && st.phase_state == SPU_S6) begin
                    next_st.sclk = 1'b1; // [R4]
                end
                if (st.phase && st.phase_state == SPU_S5) begin
                    next_st.m0_s5 = shift_data_pin_in; // [R5]
                end
                if (st.phase && st.phase_state == SPU_S6) begin
                    next_st.m0_cyc = st.m0_cyc + 4'h1;
                    if (!st.m0_last) begin
                        next_st.rx_sh = {st.rx_sh[7:0], st.m0_s5}; // [R2] [R5]
                        if (!st.rx_sh[7]) begin
                            next_st.m0_last = 1'b1; // [R6]
                            // Eighth bit joins the seven already in, LSB first
                            next_st.serial_buffer = {st.m0_s5, st.rx_sh[0], st.rx_sh[1],
                                st.rx_sh[2], st.rx_sh[3], st.rx_sh[4], st.rx_sh[5], st.rx_sh[6]};
                        end
                    end
                end
                if (s1p1 && st.m0_last) begin
                    next_st.ctrl[SPU_CTL_RXDONE] = 1'b1; // [R6] [R23]
                    next_st.sclk = 1'b1;
                    next_st.rx_st = SPU_RX_IDLE;
                end
            end
            default: next_st.rx_st = SPU_RX_IDLE;
        endcase
        next_st.irq = next_st.ctrl[SPU_CTL_RXDONE] | next_st.ctrl[SPU_CTL_TXDONE]; // [R23]
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st <= '0;
            st.ctrl <= SPU_CTRL_RESET;
            st.txd <= 1'b1;
            st.sclk <= 1'b1;
            st.rxd_prev <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from state; data pin output enable is held off in every mode
    assign reg_rdata = st.rdata;
    assign shift_data_pin_out = st.txd;
    assign shift_data_pin_oe = 1'b0;
    assign shift_clock_pin = st.sclk;
    assign serial_irq = st.irq;
endmodule // spu_uart

// [test/spu_remote.sv]
// Remote serial partner: sends frames, glitches, and captures what it hears
`timescale 1ns/1ps
module spu_remote (
    input wire logic ref_clk,
    input wire logic tick,
    input wire logic line_in,
    output logic line_out
);
    logic [9:0] cap;
    int got = 0;
    initial line_out = 1'b1;
    // Wait n ticks of the 16x baud clock
    task automatic step(input int n);
        repeat (n) do @(posedge ref_clk); while (tick !== 1'b1);
    endtask
    // Start zero, data LSB first, ninth bit in long frames, stop; line idles high
    task automatic send(input logic [7:0] d, input logic long9, input logic b9, input logic stp);
        logic [10:0] f;
        f = long9 ? {stp, b9, d, 1'b0} : {1'b1, stp, d, 1'b0};
        for (int i = 0; i < (long9 ? 11 : 10); i++) begin
            line_out <= f[i];
            step(16);
        end
        line_out <= 1'b1;
    endtask
    // Low pulse too short to win the start-bit vote
    task automatic glitch();
        line_out <= 1'b0;
        step(4);
        line_out <= 1'b1;
        step(32);
    endtask
    // Sample mid-bit for ten bit times after the falling edge that starts each frame
    initial forever begin
        @(negedge line_in);
        step(8);
        for (int i = 0; i < 10; i++) begin
            step(16);
            cap[i] = line_in;
        end
        got++;
    end
endmodule // spu_remote

// [test/spu_uart_properties.sv]
// Port assertions for the serial port block
`timescale 1ns/1ps
module spu_uart_chk (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic timer_overflow,
    input wire logic shift_data_pin_in,
    input wire logic shift_data_pin_out,
    input wire logic shift_data_pin_oe,
    input wire logic shift_clock_pin,
    input wire logic serial_irq
);
    import spu_pkg::*;
    logic [1:0] mode;
    logic [7:0] nt;
    wire logic ctrl_wr = reg_wr && reg_addr == SPU_REG_CTRL;
    wire logic [7:0] tk = {7'h0, timer_overflow};
    // Mode shadow; ticks counted from each falling edge of the data line
    always_ff @(posedge ref_clk) begin
        mode <= rst ? 2'h0 : (ctrl_wr ? reg_wdata[7:6] : mode);
        nt <= $fell(shift_data_pin_out) ? tk : (nt == 8'hff ? nt : nt + tk);
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    reset_idle_a: assert property ($fell(rst) |-> shift_data_pin_out && !serial_irq)
        else $error("outputs not idle after reset");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
    unmapped_read_a: assert property (reg_rd && reg_addr == 2'h3 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    irq_sticky_a: assert property ($fell(serial_irq) |-> $past(ctrl_wr) || $past(ctrl_wr, 2))
        else $error("interrupt dropped without a clear");
    oe_off_a: assert property (!shift_data_pin_oe)
        else $error("data pin driven");
    // The start bit waits for S1P1 after a rollover, so it is short by under one tick
    bit_edge_a: assert property ($rose(shift_data_pin_out) && mode != 2'h2
        |-> (nt[3:0] == 4'hf || nt[3:0] == 4'h0) && nt != 8'h00)
        else $error("line edge off a bit boundary");
    low_run_a: assert property (!shift_data_pin_out && mode != 2'h2 && !$fell(shift_data_pin_out)
        |-> nt < (mode[1] ? 8'd160 : 8'd144)) else $error("line low longer than a frame");
    sclk_idle_a: assert property (mode != 2'h0 && $past(mode) != 2'h0 |-> shift_clock_pin)
        else $error("shift clock moved outside mode 0");
    cover property ($fell(shift_data_pin_out));
    cover property ($rose(serial_irq));
    cover property (reg_rd && reg_addr == 2'h3);
endmodule // spu_uart_chk
bind spu_uart spu_uart_chk chk (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .timer_overflow, .shift_data_pin_in, .shift_data_pin_out, .shift_data_pin_oe,
    .shift_clock_pin, .serial_irq);

// [test/tb_spu_uart.sv]
// Self-checking bench for the serial port block
`timescale 1ns/1ps
module tb_spu_uart;
    import spu_pkg::*;
    typedef struct packed {
        logic tx;
        logic [7:0] ctrl;
        logic [7:0] data;
        logic b9;
        logic stp;
        logic load;
    } spu_row_t;
    logic ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, timer_overflow = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, v;
    logic rxd, txd, oe, sclk, irq;
    int n_mismatch = 0, check_count = 0, div = 0, g, n_sclk = 0;
    // Falling edges of the mode 0 shift clock
    always @(negedge sclk) n_sclk++;
    // Receive rows first, then transmit rows; filter cases with a zero stop or ninth bit drop frames
    spu_row_t rows [9] = '{
        {1'b0, 8'h50, 8'ha5, 1'b0, 1'b1, 1'b1}, {1'b0, 8'h70, 8'h3c, 1'b0, 1'b0, 1'b0},
        {1'b0, 8'h50, 8'h81, 1'b0, 1'b0, 1'b1}, {1'b0, 8'hd0, 8'h3c, 1'b0, 1'b1, 1'b1},
        {1'b0, 8'hf0, 8'h66, 1'b0, 1'b1, 1'b0}, {1'b0, 8'hf0, 8'h99, 1'b1, 1'b1, 1'b1},
        {1'b1, 8'h40, 8'h96, 1'b0, 1'b1, 1'b1}, {1'b1, 8'hc8, 8'h5a, 1'b0, 1'b1, 1'b1},
        {1'b1, 8'hc0, 8'h0f, 1'b0, 1'b1, 1'b1}};
    spu_uart uut (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .timer_overflow, .shift_data_pin_in(rxd), .shift_data_pin_out(txd),
        .shift_data_pin_oe(oe), .shift_clock_pin(sclk), .serial_irq(irq));
    spu_remote remote (.ref_clk, .tick(timer_overflow), .line_in(txd), .line_out(rxd));
    always #2 ref_clk = ~ref_clk;
    // 16x tick once per machine cycle of twelve clocks
    always @(posedge ref_clk) begin
        div <= (div == 11) ? 0 : div + 1;
        timer_overflow <= (div == 11);
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [1:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic poll(input int b);
        for (int i = 0; i < 150 && v[b] !== 1'b1; i++) rd(SPU_REG_CTRL);
    endtask
    task automatic do_rx(input spu_row_t r);
        remote.send(r.data, r.ctrl[7], r.b9, r.stp);
        v = 8'h00;
        poll(SPU_CTL_RXDONE);
        chk({7'h0, v[SPU_CTL_RXDONE]}, {7'h0, r.load});
        if (r.load) begin
            chk({7'h0, v[SPU_CTL_RX9]}, {7'h0, r.ctrl[7] ? r.b9 : r.stp});
            rd(SPU_REG_BUF);
            chk(v, r.data);
        end
    endtask
    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        rd(SPU_REG_CTRL);
        chk(v, SPU_CTRL_RESET);
        wr(2'h3, 8'hff);
        rd(2'h3);
        chk(v, 8'h00);
        rd(SPU_REG_CTRL);
        chk(v, SPU_CTRL_RESET);
        foreach (rows[i]) begin
            wr(SPU_REG_CTRL, rows[i].ctrl);
            if (!rows[i].tx) do_rx(rows[i]);
            else begin
                g = remote.got;
                wr(SPU_REG_BUF, rows[i].data);
                for (int k = 0; k < 4000 && remote.got == g; k++) @(posedge ref_clk);
                if (remote.got == g) begin
                    n_mismatch++;
                    print_verdict();
                end
                chk(remote.cap[7:0], rows[i].data);
                chk({7'h0, remote.cap[8]}, {7'h0, rows[i].ctrl[7] ? rows[i].ctrl[3] : 1'b1});
                chk({7'h0, remote.cap[9]}, 8'h01);
                v = 8'h00;
                poll(SPU_CTL_TXDONE);
                chk({7'h0, v[SPU_CTL_TXDONE]}, 8'h01);
                chk({7'h0, irq}, 8'h01);
            end
        end
        // A frame arriving while the done flag is set must not reach the buffer
        wr(SPU_REG_CTRL, 8'h50);
        do_rx(rows[0]);
        remote.send(8'h22, 1'b0, 1'b0, 1'b1);
        repeat (300) @(posedge ref_clk);
        rd(SPU_REG_BUF);
        chk(v, 8'ha5);
        // A short low pulse is no start bit; the next real frame still lands
        wr(SPU_REG_CTRL, 8'h50);
        remote.glitch();
        rd(SPU_REG_CTRL);
        chk({7'h0, v[SPU_CTL_RXDONE]}, 8'h00);
        do_rx(rows[2]);
        // Mode 0 receive with the data pin idle high: eight shift clocks, all ones
        wr(SPU_REG_CTRL, 8'h10);
        g = n_sclk;
        v = 8'h00;
        poll(SPU_CTL_RXDONE);
        chk({7'h0, v[SPU_CTL_RXDONE]}, 8'h01);
        chk(8'(n_sclk - g), 8'h08);
        rd(SPU_REG_BUF);
        chk(v, 8'hff);
        wr(SPU_REG_CTRL, 8'h00);
        repeat (2) @(posedge ref_clk);
        #1;
        chk({7'h0, irq}, 8'h00);
        print_verdict();
    end
    // Bound on the whole run
    initial begin
        repeat (100000) @(posedge ref_clk);
        n_mismatch++;
        print_verdict();
    end
endmodule // tb_spu_uart
